/* File: dv/ipid_identifier_properties.sv */
// assertions on the interrupt pending identifier ports
`timescale 1ns/1ps
module ipid_props #(
   parameter NMOD = 6,
   parameter NSRC = 8,
   parameter NSYS = 4
) (
   input wire                 mclk,
   input wire                 reset,
   input wire [NMOD*NSRC-1:0] mod_src_enable,
   input wire [NMOD*NSRC-1:0] mod_src_flag,
   input wire [NSYS-1:0]      sys_src_enable,
   input wire [NSYS-1:0]      sys_src_flag,
   input wire [7:0]           interrupt_identification,
   input wire                 module0_pending,
   input wire                 module5_pending,
   input wire                 system_pending
);
   logic [7:0] ex;
   always_comb begin
      ex = 8'h00;
      for (int m = 0; m < 6; m++)
         ex[m] = |(mod_src_enable[m*NSRC+:NSRC] & mod_src_flag[m*NSRC+:NSRC]);
      ex[7] = |(sys_src_enable & sys_src_flag);
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   mod_bits_a: assert property (!$past(reset) |->
      interrupt_identification[5:0] == $past(ex[5:0]))
      else $error("module bits wrong");
   pin_map_a: assert property ({module5_pending, module0_pending, system_pending} ==
      {interrupt_identification[5], interrupt_identification[0], interrupt_identification[7]})
      else $error("pending pins differ");
   sys_bit_a: assert property (!$past(reset) |->
      interrupt_identification[7] == $past(ex[7]))
      else $error("system bit wrong");
   set_cause_a: assert property ($rose(module0_pending) |-> $past(ex[0]))
      else $error("bit set without source");
   clear_bits_a: assert property (!$past(reset) && $past(ex[5:0]) == 6'h00 |->
      interrupt_identification[5:0] == 6'h00)
      else $error("bit not cleared");
   rst_zero_a: assert property (disable iff (1'b0) reset |=>
      interrupt_identification == 8'h00)
      else $error("not zero after reset");
   rsvd_zero_a: assert property (interrupt_identification[6] == 1'b0)
      else $error("bit six set");
   hold_id_a: assert property (!$past(reset) && $stable(ex) |=>
      $stable(interrupt_identification))
      else $error("bits moved without source");
   cover property ($rose(module0_pending));
   cover property ($rose(system_pending));
   cover property ($fell(module5_pending));
endmodule // ipid_props
bind ipid_identifier ipid_props #(.NMOD(NMOD), .NSRC(NSRC), .NSYS(NSYS)) i_ipid_props (
   .mclk(mclk), .reset(reset), .mod_src_enable(mod_src_enable), .mod_src_flag(mod_src_flag),
   .sys_src_enable(sys_src_enable), .sys_src_flag(sys_src_flag),
   .interrupt_identification(interrupt_identification), .module0_pending(module0_pending),
   .module5_pending(module5_pending), .system_pending(system_pending));

/* File: dv/ipid_identifier_test.sv */
// self-checking bench for the interrupt pending identifier
`timescale 1ns/1ps
module ipid_identifier_test;
   reg  [47:0] en = 0, fl = 0;
   reg  [3:0]  se = 0, sf = 0, adr = 0;
   reg  [31:0] wd = 0, q;
   reg         mclk = 0, reset = 1, rd = 0, wr = 0;
   wire [31:0] rdat;
   wire [7:0]  id;
   wire [6:0]  pin;
   wire        wait_r, irq;
   int         num_errors = 0, checked = 0;
   always #12.5 mclk = ~mclk;
   ipid_identifier i_ipid_identifier (.mclk(mclk), .reset(reset), .mod_src_enable(en),
      .mod_src_flag(fl), .sys_src_enable(se), .sys_src_flag(sf), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
      .avs_readdata(rdat), .avs_waitrequest(wait_r), .interrupt_identification(id),
      .module0_pending(pin[0]), .module1_pending(pin[1]), .module2_pending(pin[2]),
      .module3_pending(pin[3]), .module4_pending(pin[4]), .module5_pending(pin[5]),
      .system_pending(pin[6]), .irq(irq));
   task chk(input [31:0] s, input [31:0] e, input [63:0] nm);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %0s exp %h seen %h", nm, e, s);
      end
   endtask
   task bus(input w, input [3:0] a, input [31:0] d);
      @(posedge mclk);
      adr <= a;
      rd <= !w;
      wr <= w;
      wd <= d;
      do begin
         @(posedge mclk);
      end while (wait_r !== 1'b0);
      q = rdat;
      rd <= 0;
      wr <= 0;
   endtask
   task src(input [47:0] e, input [47:0] f, input [3:0] a, input [3:0] b);
      @(posedge mclk);
      en <= e;
      fl <= f;
      se <= a;
      sf <= b;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task t_mods;
      for (int m = 0; m < 6; m++) begin
         src(48'h1 << (m*9), 48'h2 << (m*9), 0, 0);
         chk(id, 0, "mis");
         src(48'h1 << (m*9), 48'h1 << (m*9), 0, 0);
         chk(id, 32'h1 << m, "one");
         chk(pin, 32'h1 << m, "pin");
         src(m % 2 ? 48'h1 << (m*9) : 0, m % 2 ? 0 : 48'h1 << (m*9), 0, 0);
         chk(id, 0, "off");
      end
   endtask
   task t_sys;
      src(0, 0, 4'h8, 4'h8);
      chk(id, 8'h80, "sys");
      chk(pin, 32'h40, "sys_pin");
      src({48{1'b1}}, {48{1'b1}}, 4'hF, 4'hF);
      bus(1, 0, 32'hFF);
      bus(0, 0, 0);
      chk(q, 8'hBF, "rd_id");
      bus(1, 0, 0);
      bus(0, 0, 0);
      chk(q, 8'hBF, "wr0_id");
      src(0, 0, 0, 0);
      chk(id, 0, "wr_id");
   endtask
   task t_irq;
      bus(1, 4, 32'hFF);
      bus(1, 8, 2);
      bus(0, 8, 0);
      chk(q, 2, "mask");
      src(1, 1, 0, 0);
      chk(irq, 0, "masked");
      bus(0, 4, 0);
      chk(q, 1, "status");
      bus(1, 8, 1);
      repeat (2) @(posedge mclk);
      chk(irq, 1, "irq");
      src(0, 0, 0, 0);
      bus(1, 4, 1);
      repeat (2) @(posedge mclk);
      chk(irq, 0, "clr");
      bus(0, 4'hC, 0);
      chk(q, 0, "unmap");
   endtask
   task close_out;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 0;
      #1;
      chk(id, 0, "rst");
      bus(0, 0, 0);
      chk(q, 0, "rst_rd");
      t_mods;
      t_sys;
      t_irq;
      close_out;
   end
   initial begin
      #20000;
      num_errors++;
      close_out;
   end
endmodule // ipid_identifier_test

/* File: rtl/ipid_defs.vh */
// register offsets, field positions and reset values of the interrupt pending identifier
`ifndef IPID_DEFS_VH
`define IPID_DEFS_VH

`define IPID_NUM_MODULES     6
`define IPID_SRCS_PER_MODULE 8
`define IPID_SYS_SRCS        4

`define IPID_ADDR_W          4
`define IPID_DATA_W          32
`define IPID_REG_W           8

`define IPID_OFS_IDENT       4'h0
`define IPID_OFS_STATUS      4'h4
`define IPID_OFS_MASK        4'h8

`define IPID_BIT_RSVD        6
`define IPID_BIT_SYS         7

`define IPID_IDENT_RESET     8'h00
`define IPID_STATUS_RESET    8'h00
`define IPID_MASK_RESET      8'h00
`define IPID_RSVD_MASK       8'h40
`define IPID_UNMAPPED_DATA   32'h00000000

`endif

/* File: rtl/ipid_identifier.v */
// interrupt pending identifier with its avalon-mm register slave
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "ipid_defs.vh"

// Function
// R1: Bits zero to five each show whether peripheral module zero to five has an interrupt pending.
// R2: Bit seven shows a pending interrupt from system-level sources such as the watchdog.
// R3: A module bit is set only when some source in that module is enabled and flagged.
// R4: A module bit clears once all its sources are disabled or have their flags cleared.
// R5: The identification register is zero after any reset and is read-only.
// R6: Bit six is unused and always reads as zero.
// R7: Writes to the identification register are ignored and its bits follow the sources.
module ipid_identifier #(
   parameter NMOD = `IPID_NUM_MODULES,
   parameter NSRC = `IPID_SRCS_PER_MODULE,
   parameter NSYS = `IPID_SYS_SRCS
) (
   input  wire                       mclk,
   input  wire                       reset,
   input  wire [NMOD*NSRC-1:0]       mod_src_enable,
   input  wire [NMOD*NSRC-1:0]       mod_src_flag,
   input  wire [NSYS-1:0]            sys_src_enable,
   input  wire [NSYS-1:0]            sys_src_flag,
   input  wire [`IPID_ADDR_W-1:0]    avs_address,
   input  wire                       avs_read,
   input  wire                       avs_write,
   input  wire [`IPID_DATA_W-1:0]    avs_writedata,
   input  wire [3:0]                 avs_byteenable,
   output reg  [`IPID_DATA_W-1:0]    avs_readdata,
   output wire                       avs_waitrequest,
   output wire [`IPID_REG_W-1:0]     interrupt_identification,
   output wire                       module0_pending,
   output wire                       module1_pending,
   output wire                       module2_pending,
   output wire                       module3_pending,
   output wire                       module4_pending,
   output wire                       module5_pending,
   output wire                       system_pending,
   output reg                        irq
);

   wire [NMOD-1:0]             mod_pend;
   wire                        sys_pend;
   wire [`IPID_REG_W-1:0]      ident_d;
   reg  [`IPID_REG_W-1:0]      ident_q;
   wire [`IPID_REG_W-1:0]      rise;
   reg  [`IPID_REG_W-1:0]      status_q;
   reg  [`IPID_REG_W-1:0]      status_d;
   reg  [`IPID_REG_W-1:0]      mask_q;
   reg  [`IPID_REG_W-1:0]      mask_d;
   reg                         ack_q;
   wire                        ack_d;
   wire                        req;
   wire                        wr_take;
   wire                        rd_load;
   reg                         sel_ident;
   reg                         sel_status;
   reg                         sel_mask;
   reg  [`IPID_DATA_W-1:0]     rdata_d;
   wire [`IPID_REG_W-1:0]      wr_byte;
   wire                        irq_d;

   genvar g;

   // one reducer per peripheral module
   // R3: enabled and flagged
   // R4: clears with last source
   generate
      for (g = 0; g < NMOD; g = g + 1) begin : g_mod
         ipid_pend_reduce #(
            .W (NSRC)
         ) u_red (
            .src_enable (mod_src_enable[g*NSRC +: NSRC]),
            .src_flag   (mod_src_flag[g*NSRC +: NSRC]),
            .pending    (mod_pend[g])
         );
      end
   endgenerate

   // R2: system sources
   ipid_pend_reduce #(
      .W (NSYS)
   ) u_sys (
      .src_enable (sys_src_enable),
      .src_flag   (sys_src_flag),
      .pending    (sys_pend)
   );

   // R1: module bits low
   // R2: system bit on top
   // R6: reserved bit zero
   // module bits beyond the module count, and bit six, read zero
   generate
      for (g = 0; g < `IPID_REG_W; g = g + 1) begin : g_ident
         if (g < NMOD && g < `IPID_BIT_RSVD) begin : g_mod_bit
            assign ident_d[g] = mod_pend[g];
         end else if (g == `IPID_BIT_SYS) begin : g_sys_bit
            assign ident_d[g] = sys_pend;
         end else begin : g_zero_bit
            assign ident_d[g] = 1'b0;
         end
      end
   endgenerate

   // registered so the read mux and the status edge detector share one
   // settled copy per clock; costs one cycle of latency
   // R7: follows sources each clock
   // R5: zero on reset
   always @(posedge mclk) begin
      if (reset) begin
         ident_q <= `IPID_IDENT_RESET;
      end else begin
         ident_q <= ident_d & ~`IPID_RSVD_MASK;
      end
   end

   assign interrupt_identification = ident_q;
   assign module0_pending          = ident_q[0];
   assign module1_pending          = ident_q[1];
   assign module2_pending          = ident_q[2];
   assign module3_pending          = ident_q[3];
   assign module4_pending          = ident_q[4];
   assign module5_pending          = ident_q[5];
   assign system_pending           = ident_q[`IPID_BIT_SYS];

   // a new pending bit is an event for the sticky status
   assign rise = ident_d & ~ident_q & ~`IPID_RSVD_MASK;

   // bus handshake: waitrequest high in the first cycle, low in the second
   // exactly one wait state, so read data load while waiting and stand at
   // the answer edge; a back-to-back request starts a fresh wait
   assign req             = avs_read | avs_write;
   assign ack_d           = req & ~ack_q;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_take         = avs_write & ack_q;
   assign rd_load         = avs_read & ~ack_q;
   // only byte lane 0 reaches the registers
   assign wr_byte         = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

   always @(posedge mclk) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   // address decode
   // the identification offset has no write path, so writes there fall away
   always @* begin
      sel_ident  = 1'b0;
      sel_status = 1'b0;
      sel_mask   = 1'b0;
      if (avs_address == `IPID_OFS_IDENT) begin
         sel_ident = 1'b1;
      end else if (avs_address == `IPID_OFS_STATUS) begin
         sel_status = 1'b1;
      end else if (avs_address == `IPID_OFS_MASK) begin
         sel_mask = 1'b1;
      end
   end

   // sticky status: write one clears, a new event wins over the clear
   // bit six is forced low here too, so no path can ever set it
   always @* begin
      status_d = status_q;
      if (wr_take && sel_status) begin
         status_d = status_q & ~wr_byte;
      end
      status_d = (status_d | rise) & ~`IPID_RSVD_MASK;
   end

   always @* begin
      mask_d = mask_q;
      if (wr_take && sel_mask) begin
         mask_d = wr_byte & ~`IPID_RSVD_MASK;
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         status_q <= `IPID_STATUS_RESET;
         mask_q   <= `IPID_MASK_RESET;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_d;
      end
   end

   // read mux; R7: ident writes dropped
   always @* begin
      rdata_d = `IPID_UNMAPPED_DATA;
      if (sel_ident) begin
         rdata_d = {24'h000000, ident_q};
      end else if (sel_status) begin
         rdata_d = {24'h000000, status_q};
      end else if (sel_mask) begin
         rdata_d = {24'h000000, mask_q};
      end
   end

   // read data captured in the waiting cycle, stands at the answer edge
   always @(posedge mclk) begin
      if (reset) begin
         avs_readdata <= `IPID_UNMAPPED_DATA;
      end else if (rd_load) begin
         avs_readdata <= rdata_d;
      end
   end

   // next-state values let a mask write or a clear act at its own edge
   assign irq_d = |(status_d & mask_d);

   always @(posedge mclk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_d;
      end
   end

endmodule // ipid_identifier

/* File: rtl/ipid_pend_reduce.v */
// reduction of one module's enable and flag vectors into a pending level
`timescale 1ns/1ps

module ipid_pend_reduce #(
   parameter W = 8
) (
   input  wire [W-1:0] src_enable,
   input  wire [W-1:0] src_flag,
   output wire         pending
);

   // R3: enabled and flagged
   // R4: clears with last source
   assign pending = |(src_enable & src_flag);

endmodule // ipid_pend_reduce
